// ---- tag_pkg.sv ----
// tag_pkg: word map, field positions, reset values and carriers for the
// nonvolatile map and mode block.
// assumes: one 40 MHz clock, synchronous active-low reset.
// Behaviour
// - level-3 mode puts every block in fifo
// - level-4, level-3: activation interrupt after second cascade acknowledge
// - level-3, transparent: serial access despite field
// - transparent, select high: data pin drives modulator
// - transparent: carrier on data-out, demodulated on irq
// - select low restores ordinary serial pins
// - thirty-two words of thirty-two bits
// - words zero and one never written
// - config and user words writable unless locked
// - words three, four: ones never cleared
// - word zero holds low identifier bytes
// - frame size index defaults to two
// - frame waiting index defaults to six
// - b23 reports equal rates only
// - b22..b20 advertise tag-to-reader rates
// - b19..b17 advertise reader-to-tag rates
// - b16 acknowledge says no level-4
// - b15 acknowledge says passive target
// - two mode bits pick protocol mode
// - no-level-4 wins over passive target
// - write lock bit makes word read-only
// - read lock hides user word from reader only
package tag_pkg;
  localparam int unsigned WORDS  = 32;
  localparam int unsigned WORD_W = 32;
  // word addresses
  localparam logic [4:0] A_UID   = 5'h00;
  localparam logic [4:0] A_FAB   = 5'h01;
  localparam logic [4:0] A_CFG   = 5'h02;
  localparam logic [4:0] A_WLOCK = 5'h03;
  localparam logic [4:0] A_RLOCK = 5'h04;
  localparam logic [4:0] A_USER  = 5'h05;
  // configuration field positions (low bit of each field)
  localparam int unsigned B_FSCI = 28;
  localparam int unsigned B_FWI  = 24;
  localparam int unsigned B_EQ   = 23;
  localparam int unsigned B_T2R  = 20;
  localparam int unsigned B_R2T  = 17;
  localparam int unsigned B_NOL4 = 16;
  localparam int unsigned B_PASV = 15;
  localparam int unsigned B_AIRQ = 13;
  localparam int unsigned B_MODE = 11;
  // reset values
  localparam logic [3:0]  FSCI_RESET = 4'h2;
  localparam logic [3:0]  FWI_RESET  = 4'h6;
  localparam logic [31:0] CFG_RESET  = 32'h2600_0000;
  localparam logic [2:0]  SYNC_RESET = 3'h7;
  // operating modes
  localparam logic [1:0] MODE_L4     = 2'h0;
  localparam logic [1:0] MODE_L3     = 2'h1;
  localparam logic [1:0] MODE_FRAME  = 2'h2;
  localparam logic [1:0] MODE_TRANSP = 2'h3;
  // select acknowledge bits
  localparam logic [7:0] SAK_L4   = 8'h20;
  localparam logic [7:0] SAK_PASV = 8'h40;
  // first-byte codes handled locally in level-4 mode
  localparam logic [7:0] RATS_CODE = 8'hE0;
  localparam logic [3:0] PPS_HI    = 4'hD;
  localparam logic [3:0] DESEL_HI  = 4'hC;
  localparam logic [2:0] DESEL_LO  = 3'h2;
  localparam logic [1:0] PROP_HI   = 2'h1;

  typedef enum logic [1:0] {acc_ok, acc_locked, acc_read_only, acc_blocked} acc_status_t;

  typedef struct packed {
    logic        valid;
    logic        write;
    logic [4:0]  addr;
    logic [31:0] wdata;
  } acc_req_t;

  typedef struct packed {
    logic        ack;
    acc_status_t status;
    logic [31:0] rdata;
  } acc_rsp_t;

  typedef struct packed {
    logic [3:0] fsci;
    logic [3:0] fwi;
    logic [7:0] rate;
    logic [7:0] sak;
    logic [1:0] mode;
    logic       act_irq_en;
  } cfg_view_t;
endpackage

// ---- word_guard.sv ----
// word_guard: verdict and new content for one word access.
// assumes: caller supplies the addressed word and both lock words.
module word_guard (
  // access being served
  input  tag_pkg::acc_req_t    req,
  input  wire logic            from_reader,
  input  wire logic            allowed,
  // current content
  input  wire logic [31:0]     old_word,
  input  wire logic [31:0]     wlock,
  input  wire logic [31:0]     rlock,
  // verdict
  output tag_pkg::acc_status_t status,
  output logic                 do_write,
  output logic [31:0]          new_word,
  output logic [31:0]          rdata
);
  logic otp;

  // lock words only ever gain ones
  assign otp = (req.addr == tag_pkg::A_WLOCK) || (req.addr == tag_pkg::A_RLOCK);

  // write and read decisions; one port at a time reaches here
  always_comb
  begin
    status   = tag_pkg::acc_ok;
    do_write = 1'b0;
    new_word = old_word;
    rdata    = old_word;
    if (!allowed)
    begin
      status = tag_pkg::acc_blocked;
      rdata  = 32'h0000_0000;
    end
    else if (req.write)
    begin
      rdata = 32'h0000_0000;
      if (req.addr <= tag_pkg::A_FAB)
        status = tag_pkg::acc_read_only;
      else if (wlock[req.addr])
        status = tag_pkg::acc_locked;
      else
      begin
        do_write = 1'b1;
        new_word = otp ? (old_word | req.wdata) : req.wdata;
      end
    end
    else if (from_reader && req.addr >= tag_pkg::A_USER && rlock[req.addr])
      rdata = 32'h0000_0000;
  end
endmodule // word_guard

// ---- tag_eeprom_map_and_modes.sv ----
// tag_eeprom_map_and_modes: word store, access arbitration, config
// decode, block routing, activation interrupt and transparent pin mux.
// assumes: protocol engine and front end share the clock; the serial
// select pin is asynchronous and is synchronised here.
module tag_eeprom_map_and_modes #(
  parameter logic [31:0] UID_LOW  = 32'h1234_5678, // arbitrary value
  parameter logic [31:0] FAB_DATA = 32'h0000_0000  // arbitrary value
) (
  // clock and reset
  input  wire logic          clock,
  input  wire logic          rst_b,
  // reader-side word access
  input  tag_pkg::acc_req_t  rd_req,
  output logic               rd_ready,
  output tag_pkg::acc_rsp_t  rd_rsp,
  // serial-side word access
  input  tag_pkg::acc_req_t  sp_req,
  output logic               sp_ready,
  output tag_pkg::acc_rsp_t  sp_rsp,
  // protocol engine events
  input  wire logic          field_on,
  input  wire logic          active_entry,
  input  wire logic          irq_clear,
  input  wire logic          rats_window,
  input  wire logic          blk_valid,
  input  wire logic [7:0]    blk_first,
  output logic               blk_to_fifo,
  output logic               blk_local,
  output logic               act_irq,
  output tag_pkg::cfg_view_t cfg,
  output logic [31:0]        uid_low,
  // serial pins
  input  wire logic          ss_b_pin,
  input  wire logic          mosi_pin,
  output logic               miso_o,
  output logic               miso_oe,
  output logic               irq_pin,
  // protocol engine pin side
  input  wire logic          proto_miso,
  input  wire logic          proto_miso_oe,
  input  wire logic          proto_irq,
  input  wire logic          proto_mod,
  // front end
  input  wire logic          front_end_carrier,
  input  wire logic          front_end_demod,
  output logic               mod_on
);

  ////////////////////////////////////////////////////////////////////
  // state
  typedef struct packed {
    logic [tag_pkg::WORDS-1:0][tag_pkg::WORD_W-1:0] mem;
    tag_pkg::acc_rsp_t rd_rsp;
    tag_pkg::acc_rsp_t sp_rsp;
    logic              act_irq;
    logic              to_fifo;
    logic              local_cmd;
    logic [2:0]        ss_sync;
    logic              ss_level;
  } state_t;

  state_t              state_q;
  state_t              state_d;
  tag_pkg::acc_req_t   req;
  tag_pkg::acc_status_t g_status;
  logic                g_write;
  logic [31:0]         g_new;
  logic [31:0]         g_rdata;
  logic                take_rd;
  logic                take_sp;
  logic                sp_allowed;
  logic                local_hit;
  logic                proto_mode;
  logic                transp_sel;
  logic [31:0]         cfg_word;

  ////////////////////////////////////////////////////////////////////
  // configuration decode
  assign cfg_word = state_q.mem[tag_pkg::A_CFG];

  // answer-to-select rate byte and select acknowledge from config
  always_comb
  begin
    cfg.fsci = cfg_word[tag_pkg::B_FSCI +: 4];
    cfg.fwi  = cfg_word[tag_pkg::B_FWI +: 4];
    cfg.rate[7] = cfg_word[tag_pkg::B_EQ];
    cfg.rate[6:4] = cfg_word[tag_pkg::B_T2R +: 3];
    cfg.rate[3] = 1'b0;
    cfg.rate[2:0] = cfg_word[tag_pkg::B_R2T +: 3];
    if (cfg_word[tag_pkg::B_NOL4])
      cfg.sak = 8'h00;
    else if (cfg_word[tag_pkg::B_PASV])
      cfg.sak = tag_pkg::SAK_L4 | tag_pkg::SAK_PASV;
    else
      cfg.sak = tag_pkg::SAK_L4;
    cfg.mode       = cfg_word[tag_pkg::B_MODE +: 2];
    cfg.act_irq_en = cfg_word[tag_pkg::B_AIRQ];
  end

  assign uid_low = state_q.mem[tag_pkg::A_UID];

  assign proto_mode = (cfg.mode == tag_pkg::MODE_L4) || (cfg.mode == tag_pkg::MODE_L3);

  ////////////////////////////////////////////////////////////////////
  // access arbitration: reader wins a shared cycle, serial side waits
  // serial access with field
  assign sp_allowed = !field_on || (cfg.mode == tag_pkg::MODE_L3) ||
                      (cfg.mode == tag_pkg::MODE_TRANSP);
  assign rd_ready   = 1'b1;
  assign sp_ready   = !rd_req.valid;
  assign take_rd    = rd_req.valid;
  assign take_sp    = sp_req.valid && !rd_req.valid;
  assign req        = take_rd ? rd_req : sp_req;

  word_guard word_guard_inst (
    .req         (req),
    .from_reader (take_rd),
    .allowed     (take_rd || sp_allowed),
    .old_word    (state_q.mem[req.addr]),
    .wlock       (state_q.mem[tag_pkg::A_WLOCK]),
    .rlock       (state_q.mem[tag_pkg::A_RLOCK]),
    .status      (g_status),
    .do_write    (g_write),
    .new_word    (g_new),
    .rdata       (g_rdata)
  );

  ////////////////////////////////////////////////////////////////////
  // level-4 first-byte decision: locally handled command codes
  always_comb
  begin
    local_hit = 1'b0;
    if (blk_first == tag_pkg::RATS_CODE && rats_window)
      local_hit = 1'b1;
    else if (blk_first[7:4] == tag_pkg::PPS_HI && rats_window)
      local_hit = 1'b1;
    else if (blk_first[7:4] == tag_pkg::DESEL_HI && blk_first[2:0] == tag_pkg::DESEL_LO)
      local_hit = 1'b1;
    else if (blk_first[7:6] == tag_pkg::PROP_HI)
      local_hit = 1'b1;
  end

  ////////////////////////////////////////////////////////////////////
  // next state
  always_comb
  begin
    state_d = state_q;
    state_d.rd_rsp.ack = take_rd;
    state_d.sp_rsp.ack = take_sp;
    if (take_rd)
    begin
      state_d.rd_rsp.status = g_status;
      state_d.rd_rsp.rdata  = g_rdata;
    end
    if (take_sp)
    begin
      state_d.sp_rsp.status = g_status;
      state_d.sp_rsp.rdata  = g_rdata;
    end
    if ((take_rd || take_sp) && g_write)
      state_d.mem[req.addr] = g_new;
    state_d.to_fifo   = blk_valid && ((cfg.mode == tag_pkg::MODE_L3) ||
                        (cfg.mode == tag_pkg::MODE_L4 && !local_hit));
    state_d.local_cmd = blk_valid && cfg.mode == tag_pkg::MODE_L4 && local_hit;
    state_d.act_irq = (state_q.act_irq && !irq_clear) ||
                      (active_entry && cfg.act_irq_en && proto_mode);
    // select pin: three stages, level moves only when the last two agree
    state_d.ss_sync = {state_q.ss_sync[1:0], ss_b_pin};
    if (state_q.ss_sync[2] == state_q.ss_sync[1])
      state_d.ss_level = state_q.ss_sync[2];
  end

  // register; reset loads the factory image since the store has no
  // separate power-up load path in this model
  always_ff @(posedge clock)
  begin
    if (!rst_b)
    begin
      state_q                     <= '0;
      state_q.mem[tag_pkg::A_UID] <= UID_LOW;
      state_q.mem[tag_pkg::A_FAB] <= FAB_DATA;
      state_q.mem[tag_pkg::A_CFG] <= tag_pkg::CFG_RESET;
      state_q.ss_sync             <= tag_pkg::SYNC_RESET;
      state_q.ss_level            <= 1'b1;
    end
    else
      state_q <= state_d;
  end

  ////////////////////////////////////////////////////////////////////
  // outputs and transparent bypass; the bypass is combinational so the
  // carrier is not resampled by the faster system clock
  assign rd_rsp      = state_q.rd_rsp;
  assign sp_rsp      = state_q.sp_rsp;
  assign act_irq     = state_q.act_irq;
  assign blk_to_fifo = state_q.to_fifo;
  assign blk_local   = state_q.local_cmd;
  assign transp_sel  = (cfg.mode == tag_pkg::MODE_TRANSP) && state_q.ss_level;

  assign mod_on  = transp_sel ? mosi_pin : proto_mod;
  assign miso_o  = transp_sel ? front_end_carrier : proto_miso;
  assign miso_oe = transp_sel | proto_miso_oe;
  assign irq_pin = transp_sel ? front_end_demod : (proto_irq | state_q.act_irq);

  ////////////////////////////////////////////////////////////////////
  // checks
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_b);

  logic was_reset;
  always_ff @(posedge clock)
    was_reset <= !rst_b;

  a_id_words_hold: assert property (
    !was_reset |-> $stable(state_q.mem[0]) && $stable(state_q.mem[1]))
    else $error("identity word changed");

  a_locked_refuse: assert property (
    take_sp && sp_req.write && sp_allowed && sp_req.addr > tag_pkg::A_FAB &&
    state_q.mem[tag_pkg::A_WLOCK][sp_req.addr]
    |=> sp_rsp.ack && sp_rsp.status == tag_pkg::acc_locked &&
        state_q.mem[$past(sp_req.addr)] == $past(state_q.mem[sp_req.addr]))
    else $error("locked word accepted a write");

  a_user_write: assert property (
    take_rd && rd_req.write && rd_req.addr >= tag_pkg::A_USER &&
    !state_q.mem[tag_pkg::A_WLOCK][rd_req.addr]
    |=> rd_rsp.status == tag_pkg::acc_ok &&
        state_q.mem[$past(rd_req.addr)] == $past(rd_req.wdata))
    else $error("user word write lost");

  a_otp_no_clear: assert property (
    !was_reset |-> ($past(state_q.mem[3]) & ~state_q.mem[3]) == 32'h0000_0000 &&
                   ($past(state_q.mem[4]) & ~state_q.mem[4]) == 32'h0000_0000)
    else $error("one-time bit cleared");

  a_cfg_defaults: assert property (
    was_reset |-> cfg.fsci == tag_pkg::FSCI_RESET && cfg.fwi == tag_pkg::FWI_RESET)
    else $error("config defaults wrong after reset");

  a_rate_follow: assert property (
    take_sp && sp_req.write && sp_allowed && sp_req.addr == tag_pkg::A_CFG &&
    !state_q.mem[tag_pkg::A_WLOCK][tag_pkg::A_CFG]
    |=> cfg.rate[6:4] == $past(sp_req.wdata[22:20]) &&
        cfg.rate[7] == $past(sp_req.wdata[23]))
    else $error("rate byte does not follow config");

  a_no_l4_wins: assert property (
    cfg_word[tag_pkg::B_NOL4] |-> (cfg.sak & (tag_pkg::SAK_L4 | tag_pkg::SAK_PASV)) == 8'h00)
    else $error("select acknowledge claims level-4");

  a_act_irq_set: assert property (
    active_entry && cfg.act_irq_en && proto_mode && !transp_sel
    |=> act_irq && irq_pin ##1 (act_irq || $past(irq_clear)))
    else $error("activation interrupt missing");

  a_field_block: assert property (
    take_sp && field_on && cfg.mode == tag_pkg::MODE_L4
    |=> sp_rsp.ack && sp_rsp.status == tag_pkg::acc_blocked)
    else $error("serial access not blocked under field");

  a_l3_fifo: assert property (
    blk_valid && cfg.mode == tag_pkg::MODE_L3 |=> blk_to_fifo && !blk_local)
    else $error("level-3 block not queued");

  a_transp_pins: assert property (
    cfg.mode == tag_pkg::MODE_TRANSP && state_q.ss_level
    |-> miso_oe && miso_o == front_end_carrier && irq_pin == front_end_demod &&
        mod_on == mosi_pin)
    else $error("transparent routing wrong");

  a_select_low: assert property (
    !state_q.ss_level |-> miso_o == proto_miso && mod_on == proto_mod)
    else $error("serial pins not restored");

  a_read_hidden: assert property (
    take_rd && !rd_req.write && rd_req.addr >= tag_pkg::A_USER &&
    state_q.mem[tag_pkg::A_RLOCK][rd_req.addr] |=> rd_rsp.rdata == 32'h0000_0000)
    else $error("read-locked word visible to reader");

  a_read_only: assert property (
    take_sp && sp_req.write && sp_allowed && sp_req.addr <= tag_pkg::A_FAB
    |=> sp_rsp.status == tag_pkg::acc_read_only)
    else $error("identity word write not refused");

  a_l3_open: assert property (
    take_sp && field_on && cfg.mode == tag_pkg::MODE_L3
    |=> sp_rsp.ack && sp_rsp.status != tag_pkg::acc_blocked)
    else $error("serial access refused in level-3 mode");

  a_irq_clear: assert property (
    act_irq && irq_clear && !active_entry |=> !act_irq)
    else $error("activation interrupt not cleared");

  a_otp_merge: assert property (
    take_rd && rd_req.write && rd_req.addr == tag_pkg::A_WLOCK &&
    !state_q.mem[tag_pkg::A_WLOCK][tag_pkg::A_WLOCK]
    |=> state_q.mem[tag_pkg::A_WLOCK] ==
        ($past(state_q.mem[tag_pkg::A_WLOCK]) | $past(rd_req.wdata)))
    else $error("one-time word did not merge new ones");

  a_proto_pins: assert property (
    cfg.mode != tag_pkg::MODE_TRANSP |-> mod_on == proto_mod && miso_o == proto_miso)
    else $error("modulator bypassed outside transparent mode");

  a_uid_reset: assert property (
    was_reset |-> uid_low == UID_LOW)
    else $error("identifier word lost at reset");

  // reader-side config writes must show in the reply bytes next cycle
  a_eq_rate: assert property (
    take_rd && rd_req.write && rd_req.addr == tag_pkg::A_CFG &&
    !state_q.mem[tag_pkg::A_WLOCK][tag_pkg::A_CFG]
    |=> cfg.rate[7] == $past(rd_req.wdata[23]))
    else $error("equal rate bit does not follow config");

  a_rate_reader: assert property (
    take_rd && rd_req.write && rd_req.addr == tag_pkg::A_CFG &&
    !state_q.mem[tag_pkg::A_WLOCK][tag_pkg::A_CFG]
    |=> cfg.rate[3:0] == {1'b0, $past(rd_req.wdata[19:17])})
    else $error("reader rate bits do not follow config");

  a_sak_passive: assert property (
    !cfg_word[tag_pkg::B_NOL4] && cfg_word[tag_pkg::B_PASV]
    |-> cfg.sak == (tag_pkg::SAK_L4 | tag_pkg::SAK_PASV))
    else $error("passive target not reported");

  a_mode_route: assert property (
    blk_valid && cfg.mode == tag_pkg::MODE_L4 |=> blk_to_fifo ^ blk_local)
    else $error("level-4 block not routed exactly once");

  c_write_ok:   cover property (take_sp ##1 sp_rsp.status == tag_pkg::acc_ok);
  c_locked:     cover property (rd_rsp.ack && rd_rsp.status == tag_pkg::acc_locked);
  c_transp:     cover property (transp_sel ##1 !transp_sel);
  c_act_irq:    cover property ($rose(act_irq));
  c_blk_local:  cover property (blk_local);
endmodule // tag_eeprom_map_and_modes

// ---- front_end_model.sv ----
// front_end_model: far-side stand-in for the analog front end and the
// protocol engine pins that the block multiplexes.
// assumes: shares the block clock; carrier runs only while field is on.
module front_end_model (
  // clock and field
  input  wire logic clock,
  input  wire logic field_on,
  // front end
  output logic      front_end_carrier,
  output logic      front_end_demod,
  // protocol engine pin side
  output logic      proto_miso,
  output logic      proto_miso_oe,
  output logic      proto_irq,
  output logic      proto_mod
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [3:0] step_q = 4'h0;
  ////////////////////////////////////////////////////////////////////////////////
  // carrier and demod
  // patterns differ per pin so a wrong mux choice cannot match by luck
  always @(posedge clock)
  begin
    step_q            <= step_q + 4'h1;
    front_end_carrier <= field_on ? step_q[0] : 1'b0;
    front_end_demod   <= step_q[1] ^ step_q[3];
    proto_miso        <= step_q[2];
    proto_miso_oe     <= ~step_q[1];
    proto_irq         <= step_q[0] & step_q[2];
    proto_mod         <= ~step_q[0];
  end
endmodule // front_end_model

// ---- test_tag_eeprom_map_and_modes.sv ----
// test_tag_eeprom_map_and_modes: directed bench for the word map and modes.
// assumes: tag_pkg, the block and front_end_model are compiled before it.
module test_tag_eeprom_map_and_modes;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [31:0] UID_V = 32'hA5C3_0F96; // arbitrary value
  localparam logic [31:0] FAB_V = 32'h5A3C_F069; // arbitrary value
  logic clock, rst_b, rd_ready, sp_ready;
  tag_pkg::acc_req_t  rd_req, sp_req;
  tag_pkg::acc_rsp_t  rd_rsp, sp_rsp;
  tag_pkg::cfg_view_t cfg;
  logic field_on, active_entry, irq_clear, rats_window, blk_valid;
  logic [7:0] blk_first;
  logic [31:0] uid_low;
  logic blk_to_fifo, blk_local, act_irq, ss_b_pin, mosi_pin, miso_o, miso_oe, irq_pin;
  logic proto_miso, proto_miso_oe, proto_irq, proto_mod, front_end_carrier, front_end_demod;
  logic mod_on;
  int fail_count = 0;
  int n_checks = 0;
  logic [31:0] cw[4] = '{32'h26FF_8000, 32'h26A8_8000, 32'h2655_0000, 32'h2600_0000};
  logic [7:0]  sk[4] = '{8'h00, 8'h60, 8'h00, 8'h20};
  logic [7:0]  bf[8] = '{8'hE0, 8'hE0, 8'hD5, 8'hC2, 8'hCA, 8'h40, 8'h00, 8'hF0};
  logic [7:0]  bw = 8'b1111_1110; // rats_window per table entry
  logic [7:0]  bl = 8'b0011_1110; // expected local per entry, level-4 mode
  tag_eeprom_map_and_modes #(.UID_LOW(UID_V), .FAB_DATA(FAB_V)) tag_eeprom_map_and_modes_inst (
    .clock(clock), .rst_b(rst_b), .rd_req(rd_req), .rd_ready(rd_ready), .rd_rsp(rd_rsp),
    .sp_req(sp_req), .sp_ready(sp_ready), .sp_rsp(sp_rsp), .field_on(field_on),
    .active_entry(active_entry), .irq_clear(irq_clear), .rats_window(rats_window),
    .blk_valid(blk_valid), .blk_first(blk_first), .blk_to_fifo(blk_to_fifo),
    .blk_local(blk_local), .act_irq(act_irq), .cfg(cfg), .uid_low(uid_low),
    .ss_b_pin(ss_b_pin), .mosi_pin(mosi_pin), .miso_o(miso_o), .miso_oe(miso_oe),
    .irq_pin(irq_pin), .proto_miso(proto_miso), .proto_miso_oe(proto_miso_oe),
    .proto_irq(proto_irq), .proto_mod(proto_mod), .front_end_carrier(front_end_carrier),
    .front_end_demod(front_end_demod), .mod_on(mod_on));
  front_end_model front_end_model_inst (
    .clock(clock), .field_on(field_on), .front_end_carrier(front_end_carrier),
    .front_end_demod(front_end_demod), .proto_miso(proto_miso),
    .proto_miso_oe(proto_miso_oe), .proto_irq(proto_irq), .proto_mod(proto_mod));
  ////////////////////////////////////////////////////////////////////////////////
  // 40 MHz clock
  initial
  begin
    clock = 1'b0;
    forever #12.5 clock = ~clock;
  end
  ////////////////////////////////////////////////////////////////////////////////
  // verdict and comparison
  task automatic finish_test();
    if (fail_count == 0 && n_checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  task automatic chk_val(input string what, input logic [31:0] exp, input logic [31:0] got);
    n_checks++;
    if (got !== exp)
    begin
      fail_count++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask
  // one word access; request stands one cycle, answer awaited under a bound
  task automatic access(input logic rdr, input logic wr, input logic [4:0] a,
                        input logic [31:0] wd, input tag_pkg::acc_status_t es,
                        input logic [31:0] er);
    tag_pkg::acc_rsp_t r;
    int i;
    @(negedge clock);
    if (rdr)
      rd_req = '{valid: 1'b1, write: wr, addr: a, wdata: wd};
    else
      sp_req = '{valid: 1'b1, write: wr, addr: a, wdata: wd};
    #1;
    chk_val("rd_ready", 32'h1, {31'h0, rd_ready});
    chk_val("sp_ready", {31'h0, !rdr}, {31'h0, sp_ready});
    @(negedge clock);
    rd_req = '0;
    sp_req = '0;
    r = rdr ? rd_rsp : sp_rsp;
    for (i = 0; i < 3 && r.ack !== 1'b1; i++)
    begin
      @(negedge clock);
      r = rdr ? rd_rsp : sp_rsp;
    end
    if (i == 3)
    begin
      fail_count++;
      finish_test();
    end
    else
    begin
      chk_val("status", {30'h0, es}, {30'h0, r.status});
      chk_val("rdata", er, r.rdata);
    end
  endtask
  // one-cycle event pulse on a chosen input
  task automatic pulse(input int which);
    @(negedge clock);
    blk_valid = (which == 0);
    active_entry = (which == 1);
    irq_clear = (which == 2);
    @(negedge clock);
    {blk_valid, active_entry, irq_clear} = 3'h0;
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  // main sequence
  initial
  begin
    {rst_b, field_on, active_entry, irq_clear, rats_window, blk_valid} = 6'h0;
    {ss_b_pin, mosi_pin, blk_first, rd_req, sp_req} = '0;
    ss_b_pin = 1'b1;
    repeat (16) @(negedge clock);
    rst_b = 1'b1;
    // factory image
    access(0, 0, tag_pkg::A_UID, 0, tag_pkg::acc_ok, UID_V);
    chk_val("uid_low", UID_V, uid_low);
    access(0, 0, tag_pkg::A_FAB, 0, tag_pkg::acc_ok, FAB_V);
    access(0, 0, tag_pkg::A_CFG, 0, tag_pkg::acc_ok, 32'h2600_0000);
    chk_val("fsci", 32'h2, cfg.fsci);
    chk_val("fwi", 32'h6, cfg.fwi);
    for (int a = 0; a < 2; a++)
      access(a, 1, a[4:0], 32'hFFFF_FFFF, tag_pkg::acc_read_only, 0);
    access(1, 0, tag_pkg::A_UID, 0, tag_pkg::acc_ok, UID_V);
    // user words at both ends of the range, back to back
    for (int a = 5; a < 32; a += 26)
    begin
      access(0, 1, a[4:0], 32'h5A00_0000 | a, tag_pkg::acc_ok, 0);
      access(1, 0, a[4:0], 0, tag_pkg::acc_ok, 32'h5A00_0000 | a);
    end
    access(0, 1, tag_pkg::A_WLOCK, 32'h0000_0020, tag_pkg::acc_ok, 0);
    access(1, 1, tag_pkg::A_WLOCK, 32'h0000_0001, tag_pkg::acc_ok, 0);
    access(0, 0, tag_pkg::A_WLOCK, 0, tag_pkg::acc_ok, 32'h0000_0021);
    access(1, 1, 5'h05, 32'h1111_1111, tag_pkg::acc_locked, 0);
    access(0, 1, 5'h05, 32'h2222_2222, tag_pkg::acc_locked, 0);
    access(0, 0, 5'h05, 0, tag_pkg::acc_ok, 32'h5A00_0005);
    // read lock hides word 6 from the reader only
    access(0, 1, 5'h06, 32'hC0DE_0006, tag_pkg::acc_ok, 0);
    access(1, 1, tag_pkg::A_RLOCK, 32'h0000_0042, tag_pkg::acc_ok, 0);
    access(0, 1, tag_pkg::A_RLOCK, 32'h0000_0000, tag_pkg::acc_ok, 0);
    access(1, 0, tag_pkg::A_RLOCK, 0, tag_pkg::acc_ok, 32'h0000_0042);
    access(1, 0, 5'h06, 0, tag_pkg::acc_ok, 0);
    access(0, 0, 5'h06, 0, tag_pkg::acc_ok, 32'hC0DE_0006);
    access(1, 0, tag_pkg::A_FAB, 0, tag_pkg::acc_ok, FAB_V);
    // serial access under field in every mode
    field_on = 1'b1;
    for (int m = 0; m < 4; m++)
    begin
      access(1, 1, tag_pkg::A_CFG, 32'h2600_0000 | (m << 11), tag_pkg::acc_ok, 0);
      chk_val("mode", m, cfg.mode);
      if (m == 1 || m == 3)
        access(0, 0, 5'h05, 0, tag_pkg::acc_ok, 32'h5A00_0005);
      else
        access(0, 0, 5'h05, 0, tag_pkg::acc_blocked, 0);
    end
    // rate byte and select acknowledge per option word, serial side with field off
    field_on = 1'b0;
    for (int k = 0; k < 4; k++)
    begin
      access(0, 1, tag_pkg::A_CFG, cw[k], tag_pkg::acc_ok, 0);
      chk_val("rate", {cw[k][23:20], 1'b0, cw[k][19:17]}, cfg.rate);
      chk_val("sak", sk[k], cfg.sak);
    end
    field_on = 1'b1;
    // block routing, level-4 then level-3 with activation interrupt on
    for (int m = 0; m < 2; m++)
    begin
      for (int k = 0; k < 8; k++)
      begin
        blk_first = bf[k];
        rats_window = bw[k];
        pulse(0);
        chk_val("local", m == 0 && bl[k], blk_local);
        chk_val("fifo", m == 1 || !bl[k], blk_to_fifo);
      end
      access(1, 1, tag_pkg::A_CFG, 32'h2600_2800, tag_pkg::acc_ok, 0);
    end
    // activation interrupt set, seen on the pin, then cleared
    pulse(1);
    chk_val("act_irq", 1, act_irq);
    chk_val("irq_pin", 1, irq_pin);
    pulse(2);
    chk_val("act_irq", 0, act_irq);
    access(1, 1, tag_pkg::A_CFG, 32'h2600_0800, tag_pkg::acc_ok, 0);
    pulse(1);
    chk_val("act_irq", 0, act_irq);
    // transparent mode, select idle high then low; select crosses a synchroniser
    access(1, 1, tag_pkg::A_CFG, 32'h2600_1800, tag_pkg::acc_ok, 0);
    repeat (6) @(negedge clock);
    for (int k = 0; k < 4; k++)
    begin
      mosi_pin = k[0];
      #1;
      chk_val("mod_on", k[0], mod_on);
      chk_val("miso_o", front_end_carrier, miso_o);
      chk_val("miso_oe", 1, miso_oe);
      chk_val("irq_pin", front_end_demod, irq_pin);
      @(negedge clock);
    end
    ss_b_pin = 1'b0;
    repeat (6) @(negedge clock);
    for (int k = 0; k < 4; k++)
    begin
      mosi_pin = ~k[0];
      #1;
      chk_val("mod_on", proto_mod, mod_on);
      chk_val("miso_o", proto_miso, miso_o);
      chk_val("miso_oe", proto_miso_oe, miso_oe);
      chk_val("irq_pin", proto_irq, irq_pin);
      @(negedge clock);
    end
    finish_test();
  end
endmodule // test_tag_eeprom_map_and_modes
